// File: fll_params.svh
// Constants for the loop clock mode controller
`ifndef FLL_PARAMS_SVH
`define FLL_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define FILTER_W 12
`define FILTER_RESET 12'h200
`define SEL_SELF 2'h0
`define SEL_INTERNAL 2'h1
`define SEL_BYPASS 2'h2
`define SEL_EXTERNAL 2'h3
`define XTAL_START_COUNT 4096
`define XTAL_CNT_W 13
`define SWITCH_GAP_NS 100
`define SWITCH_GAP_CYCLES ((`SWITCH_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_W 3
`define LOCK_TOL 4
`define UNLOCK_TOL 8
`define LOCK_SAMPLES 4
`define AVG_SAMPLES_LOG2 2
`endif

// File: fll_pkg.sv
// Types shared by the loop clock mode controller
`default_nettype none
package fll_pkg;
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_SELF,
        MODE_ENGAGED_INT,
        MODE_BYPASSED_EXT,
        MODE_ENGAGED_EXT
    } mode_t;
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_OSC,
        SRC_EXT
    } src_t;
endpackage : fll_pkg
`default_nettype wire

// File: error_window_monitor.sv
// Lock and oscillator stability detection from count error samples
`timescale 1ns/1ns
`default_nettype none
`include "fll_params.svh"
module error_window_monitor #(
    parameter int ERR_W = 8,
    parameter int LOCK_TOL = `LOCK_TOL,
    parameter int UNLOCK_TOL = `UNLOCK_TOL,
    parameter int LOCK_SAMPLES = `LOCK_SAMPLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clear,
    input wire logic sample_valid,
    input wire logic osc_static,
    input wire logic signed [ERR_W-1:0] count_error,
    output logic locked,
    output logic stable
);
    logic signed [ERR_W-1:0] prev_err, next_prev_err;
    logic have_prev, next_have_prev;
    logic [1:0] run, next_run;
    logic [3:0] lock_cnt, next_lock_cnt;
    logic next_locked, next_stable;
    logic signed [ERR_W:0] delta;
    logic inside_lock, outside_unlock, small_step;

    always_comb
    begin
        delta = $signed({count_error[ERR_W-1], count_error})
            - $signed({prev_err[ERR_W-1], prev_err});
        inside_lock = (count_error > -LOCK_TOL) && (count_error < LOCK_TOL);
        outside_unlock = (count_error > UNLOCK_TOL) || (count_error < -UNLOCK_TOL);
        small_step = (delta <= UNLOCK_TOL) && (delta >= -UNLOCK_TOL);
        next_prev_err = prev_err;
        next_have_prev = have_prev;
        next_run = run;
        next_lock_cnt = lock_cnt;
        next_locked = locked;
        next_stable = stable;
        if (clear)
        begin
            next_have_prev = 1'b0;
            next_run = 2'h0;
            next_lock_cnt = 4'h0;
            next_locked = 1'b0;
            next_stable = 1'b0;
        end
        else if (sample_valid)
        begin
            next_prev_err = count_error;
            next_have_prev = 1'b1;
            if (have_prev && small_step)
                next_run = (run == 2'h2) ? run : run + 2'h1;
            else
                next_run = 2'h0;
            if (next_run == 2'h2 && !osc_static)
                next_stable = 1'b1;
            if (!locked)
            begin
                if (inside_lock)
                begin
                    next_lock_cnt = lock_cnt + 4'h1;
                    if (next_lock_cnt == 4'(LOCK_SAMPLES))
                        next_locked = 1'b1;
                end
                else
                    next_lock_cnt = 4'h0;
            end
            else if (outside_unlock)
            begin
                next_locked = 1'b0;
                next_lock_cnt = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            prev_err <= '0;
            have_prev <= 1'b0;
            run <= 2'h0;
            lock_cnt <= 4'h0;
            locked <= 1'b0;
            stable <= 1'b0;
        end
        else
        begin
            prev_err <= next_prev_err;
            have_prev <= next_have_prev;
            run <= next_run;
            lock_cnt <= next_lock_cnt;
            locked <= next_locked;
            stable <= next_stable;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_lock_needs_run: assert property ($rose(locked) |-> $past(lock_cnt) == 4'(LOCK_SAMPLES - 1))
        else $error("lock taken without enough samples");
    a_stable_static: assert property ($rose(stable) |-> !$past(osc_static))
        else $error("stable set while oscillator static");
endmodule : error_window_monitor
`default_nettype wire

// File: fll_clock_mode_control.sv
// Clock mode controller for the internal clock generator with its loop
// Functional notes
// - Stop without debug or hold: go off
// - Debug enabled: keep running during stop
// - Hold in stop: generators on, feed off
// - Interrupt wake: settings kept, feed resumes
// - Bypassed wake: output held until reference ready
// - Reset: defaults, self-clocked, nominal filter
// - Crystal: count 4096 edges before use
// - Self-clocked entry conditions incl. reference loss
// - Self-clocked: open loop, filter writable with select 00
// - Filter write sets oscillator frequency
// - Keep frequency unless entered through reset
// - Into engaged external: keep frequency, double divider until locked
// - Off exit with X1: wait stable, close
// - Engaged internal on select 01
// - Engaged internal uses internal reference
// - Unlocked until error inside lock window
// - Locked after enough in-window samples
// - Locked: filter update every four, averaged
// - Bypassed external entry conditions
// - Bypassed: oscillator and internal reference off
// - Crystal range bit selects band
// - Lock status zero in off, self, bypassed
// - Stable flag: steady error, cleared off
// - Engaged external needs stable; reference too, except when closing after off
`timescale 1ns/1ns
`default_nettype none
`include "fll_params.svh"
module fll_clock_mode_control #(
    parameter int ERR_W = 8,
    parameter int XTAL_START_COUNT = `XTAL_START_COUNT
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic stop_req,
    input wire logic debug_enable,
    input wire logic osc_in_stop_enable,
    input wire logic [1:0] clock_select,
    input wire logic reference_select,
    input wire logic range_select,
    input wire logic reference_status,
    input wire logic loss_of_clock_flag,
    input wire logic xtal_edge,
    input wire logic osc_static,
    input wire logic filter_wr,
    input wire logic [`FILTER_W-1:0] filter_wdata,
    input wire logic sample_valid,
    input wire logic signed [ERR_W-1:0] count_error,
    output fll_pkg::mode_t mode,
    output logic lock_status,
    output logic osc_stable_flag,
    output logic [`FILTER_W-1:0] filter_value,
    output logic output_half_rate,
    output fll_pkg::src_t output_source,
    output logic output_clock_gate,
    output logic clock_feed_enable,
    output logic osc_enable,
    output logic internal_ref_enable,
    output logic loop_ref_external,
    output logic xtal_high_range
);
    fll_pkg::mode_t next_mode;
    logic pend_close, next_pend_close;
    logic off_to_bypass, next_off_to_bypass;
    logic next_half_rate;
    logic [`FILTER_W-1:0] next_filter;
    logic signed [ERR_W+1:0] acc, next_acc;
    logic [1:0] avg_cnt, next_avg_cnt;
    logic [`XTAL_CNT_W-1:0] xtal_cnt, next_xtal_cnt;
    logic xtal_ready, next_xtal_ready;
    fll_pkg::src_t next_source, want_source;
    logic [`GAP_W-1:0] gap_cnt, next_gap_cnt;
    logic go_off, ext_ready, ref_lost, mon_locked, mon_stable, engaged;
    logic signed [`FILTER_W:0] step;
    logic signed [ERR_W+1:0] sum4;

    assign go_off = stop_req && !debug_enable && !osc_in_stop_enable;
    // Only an external clock with no start-up count is ready as soon as detected
    assign ext_ready = reference_status && (!reference_select || xtal_ready);
    assign ref_lost = clock_select[1] && !reference_status && loss_of_clock_flag;
    assign engaged = (mode == fll_pkg::MODE_ENGAGED_INT) || (mode == fll_pkg::MODE_ENGAGED_EXT);
    assign lock_status = mon_locked && engaged;
    assign osc_stable_flag = mon_stable;
    assign clock_feed_enable = !stop_req || debug_enable;
    assign osc_enable = (mode != fll_pkg::MODE_OFF) && (mode != fll_pkg::MODE_BYPASSED_EXT);
    assign internal_ref_enable = osc_enable;
    // Internal reference feeds the loop until the external one is usable
    assign loop_ref_external = (mode == fll_pkg::MODE_ENGAGED_EXT) && ext_ready;
    assign xtal_high_range = reference_select && range_select;
    assign output_clock_gate = (output_source != fll_pkg::SRC_NONE) && (gap_cnt == '0)
        && (want_source == output_source) && clock_feed_enable;

    error_window_monitor #(
        .ERR_W(ERR_W)
    ) u_monitor (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clear(next_mode != mode),
        .sample_valid(sample_valid && (mode != fll_pkg::MODE_OFF)),
        .osc_static(osc_static),
        .count_error(count_error),
        .locked(mon_locked),
        .stable(mon_stable)
    );

    // Mode sequencing
    always_comb
    begin
        next_mode = mode;
        next_pend_close = pend_close;
        next_off_to_bypass = off_to_bypass;
        if (go_off)
        begin
            next_mode = fll_pkg::MODE_OFF;
            if (mode != fll_pkg::MODE_OFF)
                next_off_to_bypass = (clock_select == `SEL_BYPASS) && reference_status;
        end
        else
        begin
            unique case (mode)
                fll_pkg::MODE_OFF:
                begin
                    if (off_to_bypass)
                        next_mode = fll_pkg::MODE_BYPASSED_EXT;
                    else
                    begin
                        next_mode = fll_pkg::MODE_SELF;
                        next_pend_close = clock_select[0];
                    end
                end
                fll_pkg::MODE_SELF:
                begin
                    if (ref_lost)
                        next_pend_close = 1'b0;
                    else if (pend_close)
                    begin
                        if (mon_stable)
                        begin
                            next_pend_close = 1'b0;
                            if (clock_select == `SEL_INTERNAL)
                                next_mode = fll_pkg::MODE_ENGAGED_INT;
                            else if (clock_select == `SEL_EXTERNAL)
                                next_mode = fll_pkg::MODE_ENGAGED_EXT;
                        end
                    end
                    else if (clock_select == `SEL_INTERNAL)
                        next_mode = fll_pkg::MODE_ENGAGED_INT;
                    else if (clock_select == `SEL_BYPASS && reference_status)
                        next_mode = fll_pkg::MODE_BYPASSED_EXT;
                    else if (clock_select == `SEL_EXTERNAL && reference_status && mon_stable)
                        next_mode = fll_pkg::MODE_ENGAGED_EXT;
                end
                fll_pkg::MODE_ENGAGED_INT:
                begin
                    if (clock_select == `SEL_EXTERNAL && reference_status && mon_stable)
                        next_mode = fll_pkg::MODE_ENGAGED_EXT;
                    else if (clock_select != `SEL_INTERNAL)
                        next_mode = fll_pkg::MODE_SELF;
                end
                fll_pkg::MODE_ENGAGED_EXT:
                begin
                    if (loss_of_clock_flag && reference_status)
                        next_mode = fll_pkg::MODE_BYPASSED_EXT;
                    else if (ref_lost || clock_select != `SEL_EXTERNAL)
                        next_mode = (clock_select == `SEL_INTERNAL) ?
                            fll_pkg::MODE_ENGAGED_INT : fll_pkg::MODE_SELF;
                end
                fll_pkg::MODE_BYPASSED_EXT:
                begin
                    if (ref_lost || clock_select != `SEL_BYPASS)
                        next_mode = fll_pkg::MODE_SELF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            mode <= fll_pkg::MODE_SELF;
            pend_close <= 1'b0;
            off_to_bypass <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            pend_close <= next_pend_close;
            off_to_bypass <= next_off_to_bypass;
        end
    end

    // Filter value, averaging and divider doubling
    always_comb
    begin
        next_filter = filter_value;
        next_acc = acc;
        next_avg_cnt = avg_cnt;
        next_half_rate = output_half_rate;
        sum4 = acc + ERR_W'(count_error);
        step = '0;
        if (next_mode == fll_pkg::MODE_ENGAGED_EXT && mode != fll_pkg::MODE_ENGAGED_EXT)
            next_half_rate = 1'b1;
        else if (next_mode != fll_pkg::MODE_ENGAGED_EXT || mon_locked)
            next_half_rate = 1'b0;
        if (mode == fll_pkg::MODE_SELF && clock_select == `SEL_SELF && filter_wr)
            next_filter = filter_wdata;
        else if (engaged && sample_valid)
        begin
            if (!lock_status)
            begin
                step = (`FILTER_W+1)'(count_error);
                next_filter = `FILTER_W'(($signed({1'b0, filter_value}) - step));
                next_acc = '0;
                next_avg_cnt = 2'h0;
            end
            else if (avg_cnt == 2'h3)
            begin
                step = (`FILTER_W+1)'(sum4 >>> `AVG_SAMPLES_LOG2);
                next_filter = `FILTER_W'(($signed({1'b0, filter_value}) - step));
                next_acc = '0;
                next_avg_cnt = 2'h0;
            end
            else
            begin
                next_acc = sum4;
                next_avg_cnt = avg_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            filter_value <= `FILTER_RESET;
            acc <= '0;
            avg_cnt <= 2'h0;
            output_half_rate <= 1'b0;
        end
        else
        begin
            filter_value <= next_filter;
            acc <= next_acc;
            avg_cnt <= next_avg_cnt;
            output_half_rate <= next_half_rate;
        end
    end

    // Crystal start-up count and break-before-make source switching
    always_comb
    begin
        next_xtal_cnt = xtal_cnt;
        next_xtal_ready = xtal_ready;
        if (!reference_select || (mode == fll_pkg::MODE_OFF && !osc_in_stop_enable))
        begin
            next_xtal_cnt = '0;
            next_xtal_ready = 1'b0;
        end
        else if (xtal_edge && !xtal_ready)
        begin
            next_xtal_cnt = xtal_cnt + `XTAL_CNT_W'(1);
            if (next_xtal_cnt == `XTAL_CNT_W'(XTAL_START_COUNT))
                next_xtal_ready = 1'b1;
        end
        if (mode == fll_pkg::MODE_OFF)
            want_source = fll_pkg::SRC_NONE;
        else if (mode == fll_pkg::MODE_BYPASSED_EXT)
            want_source = ext_ready ? fll_pkg::SRC_EXT : fll_pkg::SRC_NONE;
        else
            want_source = fll_pkg::SRC_OSC;
        next_source = output_source;
        next_gap_cnt = gap_cnt;
        // The gate drops first and stays low for a whole gap, so neither clock is cut short
        if (want_source != output_source)
        begin
            if (gap_cnt == `GAP_W'(`SWITCH_GAP_CYCLES))
            begin
                next_source = want_source;
                next_gap_cnt = (want_source == fll_pkg::SRC_NONE) ? '0 : gap_cnt;
            end
            else
                next_gap_cnt = gap_cnt + `GAP_W'(1);
        end
        else if (gap_cnt != '0)
            next_gap_cnt = gap_cnt - `GAP_W'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            xtal_cnt <= '0;
            xtal_ready <= 1'b0;
            output_source <= fll_pkg::SRC_OSC;
            gap_cnt <= '0;
        end
        else
        begin
            xtal_cnt <= next_xtal_cnt;
            xtal_ready <= next_xtal_ready;
            output_source <= next_source;
            gap_cnt <= next_gap_cnt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_stop_goes_off: assert property (go_off |=> mode == fll_pkg::MODE_OFF)
        else $error("stop did not turn the generator off");
    a_debug_keeps_run: assert property (stop_req && debug_enable && mode != fll_pkg::MODE_OFF
        |=> mode != fll_pkg::MODE_OFF)
        else $error("debug stop turned the generator off");
    a_hold_feed_off: assert property (stop_req && osc_in_stop_enable && !debug_enable
        |-> !clock_feed_enable && !output_clock_gate)
        else $error("feed left on in stop with hold");
    a_bypass_wait: assert property (mode == fll_pkg::MODE_BYPASSED_EXT && !ext_ready
        |=> !output_clock_gate)
        else $error("bypassed output before reference ready");
    a_reset_defaults: assert property (!$past(rstn) |-> mode == fll_pkg::MODE_SELF
        && filter_value == `FILTER_RESET)
        else $error("reset defaults not applied");
    a_filter_write: assert property (mode == fll_pkg::MODE_SELF && clock_select == `SEL_SELF
        && filter_wr |=> filter_value == $past(filter_wdata))
        else $error("filter write lost");
    a_filter_guard: assert property (mode == fll_pkg::MODE_BYPASSED_EXT
        || mode == fll_pkg::MODE_OFF |=> $stable(filter_value))
        else $error("filter changed outside loop");
    a_lock_cleared: assert property (mode == fll_pkg::MODE_OFF || mode == fll_pkg::MODE_SELF
        || mode == fll_pkg::MODE_BYPASSED_EXT |-> !lock_status)
        else $error("lock shown outside engaged modes");
    a_bypass_power: assert property (mode == fll_pkg::MODE_BYPASSED_EXT
        |-> !osc_enable && !internal_ref_enable)
        else $error("oscillator on in bypassed mode");
    a_switch_gap: assert property ($changed(output_source) |-> !$past(output_clock_gate, 1)
        && !$past(output_clock_gate, 2))
        else $error("source switched without gap");
    a_external_entry: assert property ($rose(mode == fll_pkg::MODE_ENGAGED_EXT)
        |-> $past(mon_stable))
        else $error("engaged external without stable oscillator");

    c_off_resume: cover property (mode == fll_pkg::MODE_OFF ##1 mode == fll_pkg::MODE_SELF);
    c_int_lock: cover property (mode == fll_pkg::MODE_ENGAGED_INT && $rose(lock_status));
    c_bypass: cover property ($rose(mode == fll_pkg::MODE_BYPASSED_EXT));
    c_ext_engaged: cover property ($rose(mode == fll_pkg::MODE_ENGAGED_EXT));
endmodule : fll_clock_mode_control
`default_nettype wire

// File: ext_ref_model.sv
// Behavioural external crystal or clock source for the mode controller
`timescale 1ns/1ns
`default_nettype none
module ext_ref_model #(
    parameter int EDGE_DIV = 3
) (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic lose,
    input wire logic keep_ref,
    output logic xtal_edge,
    output logic reference_status,
    output logic loss_of_clock_flag
);
    int cnt = 0;
    initial xtal_edge = 1'b0;
    // A stopped crystal gives no edges at all, so the start-up count cannot creep
    // Rising edge, so the bench's falling-edge drive of run cannot race it
    always @(posedge clk_sys)
    begin
        cnt <= run ? (cnt + 1) % EDGE_DIV : 0;
        xtal_edge <= run && cnt == EDGE_DIV - 1;
    end
    // Loss of clock may leave the reference valid or take it away
    assign reference_status = run && !(lose && !keep_ref);
    assign loss_of_clock_flag = lose;
endmodule : ext_ref_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the loop clock mode controller
`timescale 1ns/1ns
`default_nettype none
`include "fll_params.svh"
module testbench;
    logic clk_sys = 1'b0, rstn, stop_req, debug_enable, osc_in_stop_enable;
    logic [1:0] clock_select;
    logic reference_select, range_select, reference_status, loss_of_clock_flag;
    logic xtal_edge, osc_static, filter_wr, sample_valid, run, lose, keep_ref;
    logic [`FILTER_W-1:0] filter_wdata, filter_value;
    logic signed [7:0] count_error;
    fll_pkg::mode_t mode;
    fll_pkg::src_t output_source;
    logic lock_status, osc_stable_flag, output_half_rate, output_clock_gate;
    logic clock_feed_enable, osc_enable, internal_ref_enable, loop_ref_external;
    logic xtal_high_range;
    int fail_count = 0;
    int compares = 0;
    always #25 clk_sys = ~clk_sys;
    fll_clock_mode_control #(.ERR_W(8), .XTAL_START_COUNT(8)) i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .stop_req(stop_req), .debug_enable(debug_enable),
        .osc_in_stop_enable(osc_in_stop_enable), .clock_select(clock_select),
        .reference_select(reference_select), .range_select(range_select),
        .reference_status(reference_status), .loss_of_clock_flag(loss_of_clock_flag),
        .xtal_edge(xtal_edge), .osc_static(osc_static), .filter_wr(filter_wr),
        .filter_wdata(filter_wdata), .sample_valid(sample_valid),
        .count_error(count_error), .mode(mode), .lock_status(lock_status),
        .osc_stable_flag(osc_stable_flag), .filter_value(filter_value),
        .output_half_rate(output_half_rate), .output_source(output_source),
        .output_clock_gate(output_clock_gate), .clock_feed_enable(clock_feed_enable),
        .osc_enable(osc_enable), .internal_ref_enable(internal_ref_enable),
        .loop_ref_external(loop_ref_external), .xtal_high_range(xtal_high_range)
    );
    ext_ref_model #(.EDGE_DIV(3)) i_ref (
        .clk_sys(clk_sys), .run(run), .lose(lose), .keep_ref(keep_ref),
        .xtal_edge(xtal_edge), .reference_status(reference_status),
        .loss_of_clock_flag(loss_of_clock_flag)
    );
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    task automatic wr_filter(input logic [`FILTER_W-1:0] v);
        filter_wdata = v;
        filter_wr = 1'b1;
        tick(1);
        filter_wr = 1'b0;
        tick(1);
    endtask : wr_filter
    task automatic sample(input logic signed [7:0] e);
        count_error = e;
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        tick(1);
    endtask : sample
    // Bounded wait on the mode or on the selected source; running out ends the run
    task automatic wait_val(input bit src, input logic [2:0] exp);
        int i;
        for (i = 0; i < 60 && (src ? {1'b0, output_source} : mode) !== exp; i++)
            tick(1);
        check(src ? {1'b0, output_source} : mode, exp);
        if (i == 60)
            finish_test();
    endtask : wait_val
    initial
    begin
        {rstn, stop_req, debug_enable, osc_in_stop_enable, reference_select} = 5'h00;
        {range_select, osc_static, filter_wr, sample_valid, run, lose, keep_ref} = 7'h00;
        clock_select = 2'h0;
        filter_wdata = 12'h000;
        count_error = 8'h00;
        tick(12);
        rstn = 1'b1;
        check(mode, fll_pkg::MODE_SELF);
        check(filter_value, 12'h200);
        check(output_source, fll_pkg::SRC_OSC);
        check({lock_status, osc_stable_flag, output_half_rate}, 3'h0);
        check(osc_enable, 1'b1);
        $display("Test reset done");
        wr_filter(12'h123);
        check(filter_value, 12'h123);
        clock_select = 2'h1;
        tick(1);
        check(mode, fll_pkg::MODE_ENGAGED_INT);
        check({internal_ref_enable, loop_ref_external}, 2'h2);
        wr_filter(12'h0ff);
        check(filter_value, 12'h123);
        repeat (4) sample(8'sh00);
        check(lock_status, 1'b1);
        repeat (3) sample(8'sh03);
        check(filter_value, 12'h123);
        sample(8'sh03);
        check(filter_value, 12'h120);
        sample(8'sh14);
        check(lock_status, 1'b0);
        $display("Test engaged internal done");
        clock_select = 2'h0;
        tick(1);
        check(mode, fll_pkg::MODE_SELF);
        check(lock_status, 1'b0);
        wr_filter(12'h345);
        check(filter_value, 12'h345);
        debug_enable = 1'b1;
        stop_req = 1'b1;
        tick(2);
        check({mode, clock_feed_enable}, {fll_pkg::MODE_SELF, 1'b1});
        debug_enable = 1'b0;
        osc_in_stop_enable = 1'b1;
        tick(2);
        check({osc_enable, clock_feed_enable}, 2'h2);
        osc_in_stop_enable = 1'b0;
        tick(1);
        check(mode, fll_pkg::MODE_OFF);
        check({output_clock_gate, osc_stable_flag, lock_status}, 3'h0);
        clock_select = 2'h1;
        wait_val(1'b1, fll_pkg::SRC_NONE);
        check(clock_feed_enable, 1'b0);
        stop_req = 1'b0;
        tick(1);
        check(mode, fll_pkg::MODE_SELF);
        repeat (3) sample(8'sh00);
        wait_val(1'b0, fll_pkg::MODE_ENGAGED_INT);
        check(filter_value, 12'h345);
        $display("Test stop and wake done");
        clock_select = 2'h0;
        tick(1);
        osc_static = 1'b1;
        repeat (3) sample(8'sh00);
        check(osc_stable_flag, 1'b0);
        osc_static = 1'b0;
        repeat (3) sample(8'sh00);
        check(osc_stable_flag, 1'b1);
        clock_select = 2'h3;
        run = 1'b1;
        tick(1);
        check(mode, fll_pkg::MODE_ENGAGED_EXT);
        check(output_half_rate, 1'b1);
        tick(2);
        check(loop_ref_external, 1'b1);
        lose = 1'b1;
        keep_ref = 1'b1;
        // Select follows the automatic switch to bypass, as the register logic does
        clock_select = 2'h2;
        tick(1);
        check(mode, fll_pkg::MODE_BYPASSED_EXT);
        check({output_half_rate, osc_enable, internal_ref_enable, lock_status}, 4'h0);
        wait_val(1'b1, fll_pkg::SRC_EXT);
        keep_ref = 1'b0;
        tick(1);
        check(mode, fll_pkg::MODE_SELF);
        $display("Test engaged external done");
        {lose, run, reference_select, range_select} = 4'h3;
        clock_select = 2'h2;
        tick(1);
        check(mode, fll_pkg::MODE_SELF);
        check(xtal_high_range, 1'b1);
        run = 1'b1;
        tick(1);
        check(mode, fll_pkg::MODE_BYPASSED_EXT);
        check(output_clock_gate, 1'b0);
        tick(26);
        check(output_source, fll_pkg::SRC_NONE);
        wait_val(1'b1, fll_pkg::SRC_EXT);
        tick(3);
        check(output_clock_gate, 1'b1);
        $display("Test crystal bypass done");
        stop_req = 1'b1;
        tick(1);
        check(mode, fll_pkg::MODE_OFF);
        {rstn, stop_req} = 2'h0;
        tick(2);
        rstn = 1'b1;
        check({mode, filter_value, osc_stable_flag}, {fll_pkg::MODE_SELF, 12'h200, 1'b0});
        check(output_source, fll_pkg::SRC_OSC);
        $display("Test reset from stop done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
